// [verilog/bpred_pkg.sv]
// shared constants for the dynamic branch predictor
package bpred_pkg;
  // instruction classes presented by decode
  typedef enum logic [1:0] {
    CLS_OTHER    = 2'b00,
    CLS_BRANCH   = 2'b01,
    CLS_BR_LINK  = 2'b10,
    CLS_PC_WRITE = 2'b11
  } instr_class_t;

  // penalty in core clock cycles per instruction-set state
  localparam logic [2:0] PENALTY_WIDE    = 3'h4;
  localparam logic [2:0] PENALTY_COMPACT = 3'h5;
  localparam logic [2:0] PENALTY_NONE    = 3'h0;
  localparam logic [3:0] ISSUE_LAT_MIN   = 4'h1;

  // two-bit history counter
  localparam logic [1:0] HIST_ALLOC      = 2'h2;
  localparam logic [1:0] HIST_MAX        = 2'h3;
  localparam logic [1:0] HIST_MIN        = 2'h0;
  localparam int         HIST_TAKEN_BIT  = 1;

  // defaults of the cache geometry
  localparam int ENTRIES_LOG2 = 7;
  localparam int ADDR_W       = 32;
endpackage : bpred_pkg

// [verilog/bpred_mem.sv]
// small two-port memory with registered read data
`timescale 1ns/1ps
module bpred_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset: validity lives outside in flip-flops
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : bpred_mem

// [verilog/bpred_penalty.sv]
// stall counter charging the misprediction penalty
`timescale 1ns/1ps
module bpred_penalty (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [2:0] cycles,
  output logic            busy,
  output logic      [2:0] remain
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  // load on start, count down to zero otherwise
  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      cnt_nxt = cycles;
    end else if (cnt_r != 3'h0) begin
      cnt_nxt = cnt_r - 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy   = (cnt_r != 3'h0);
  assign remain = cnt_r;
endmodule : bpred_penalty

// [verilog/bpred_top.sv]
// dynamic branch predictor: target cache, history, penalty and flush
//
// How it works
// - only plain branch and branch-with-link (wide set) and plain branch (compact) are predicted.
// - writes to the program counter predict not taken, never allocate, and pay the penalty when resolved taken.
// - a predictable branch enters the cache only when first resolved taken.
// - a cached branch is predicted from a two-bit history of its past outcomes.
// - a correct hit costs no extra cycle; the next instruction issues right after.
// - a misprediction stalls issue 4 cycles in the wide set and 5 in the compact set.
// - taken-but-predicted-not, uncached-taken, and predicted-taken-but-not all mispredict.
// - mispredicted issue latency is the minimum latency plus the state's penalty.
// - addressing modes of loads and stores add no cycles here.
// - issue is counted in the cycle an instruction is decoded and allowed to advance.
`timescale 1ns/1ps
module bpred_top #(
  parameter int ENTRIES_LOG2 = bpred_pkg::ENTRIES_LOG2,
  parameter int ADDR_W       = bpred_pkg::ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // fetch side lookup
  input  wire logic              fetch_valid,
  input  wire logic [ADDR_W-1:0] fetch_pc,
  output logic                   pred_valid,
  output logic                   pred_taken,
  output logic      [ADDR_W-1:0] pred_target,
  // decode side issue handshake
  input  wire logic              dec_valid,
  input  wire logic              dec_mem_op,
  output logic                   issue_ok,
  output logic                   issue_fire,
  // execute side resolution
  input  wire logic              res_valid,
  input  wire logic [1:0]        res_class,
  input  wire logic              res_compact,
  input  wire logic [ADDR_W-1:0] res_pc,
  input  wire logic              res_taken,
  input  wire logic [ADDR_W-1:0] res_target,
  input  wire logic              res_pred_taken,
  input  wire logic              res_pred_hit,
  output logic                   mispredict,
  output logic                   flush,
  output logic      [ADDR_W-1:0] redirect_pc,
  output logic      [2:0]        penalty_cycles,
  output logic      [3:0]        miss_issue_lat
);
  localparam int N   = 1 << ENTRIES_LOG2;
  localparam int TW  = ADDR_W - ENTRIES_LOG2 - 2;
  localparam int DW  = TW + ADDR_W;

  logic [N-1:0] valid_r;
  logic [N-1:0] valid_nxt;
  logic [1:0]   hist_r [0:N-1];
  logic [1:0]   hist_nxt [0:N-1];

  // index and tag from a word-aligned address
  function automatic logic [ENTRIES_LOG2-1:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[ENTRIES_LOG2+1:2];
  endfunction : idx_of

  function automatic logic [TW-1:0] tag_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:ENTRIES_LOG2+2];
  endfunction : tag_of

  // saturating two-bit history step
  function automatic logic [1:0] hist_step(input logic [1:0] h, input logic tk);
    if (tk) begin
      return (h == bpred_pkg::HIST_MAX) ? h : h + 2'h1;
    end
    return (h == bpred_pkg::HIST_MIN) ? h : h - 2'h1;
  endfunction : hist_step

  ////////////////////////////////////////////////////////////////////////
  // reset synchroniser
  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // resolution decode
  logic predictable;
  logic pc_write;
  logic is_miss;
  logic alloc;
  logic [ENTRIES_LOG2-1:0] ridx;

  // predictable classes
  // compact set has no branch-with-link form that is predicted
  assign predictable = (res_class == bpred_pkg::CLS_BRANCH) ||
                       ((res_class == bpred_pkg::CLS_BR_LINK) && !res_compact);
  assign pc_write    = res_class == bpred_pkg::CLS_PC_WRITE;
  assign ridx        = idx_of(res_pc);

  always_comb begin
    is_miss = 1'b0;
    if (res_valid && predictable) begin
      if (res_pred_hit) begin
        is_miss = res_pred_taken != res_taken;
      end else begin
        is_miss = res_taken;
      end
    end else if (res_valid && pc_write) begin
      // pc writes were predicted not taken
      is_miss = res_taken;
    end
  end

  // allocate only on a taken, uncached predictable branch
  assign alloc = res_valid && predictable && res_taken && !res_pred_hit;

  ////////////////////////////////////////////////////////////////////////
  // tag and target storage
  logic [DW-1:0] rd_data;
  logic [ENTRIES_LOG2-1:0] lk_idx_r;
  logic [ENTRIES_LOG2-1:0] lk_idx_nxt;
  logic [TW-1:0] lk_tag_r;
  logic [TW-1:0] lk_tag_nxt;
  logic lk_valid_r;
  logic lk_valid_nxt;

  bpred_mem #(
    .AW (ENTRIES_LOG2),
    .DW (DW)
  ) u_mem (
    .clk     (clk),
    .rd_addr (idx_of(fetch_pc)),
    .rd_data (rd_data),
    .wr_en   (alloc),
    .wr_addr (ridx),
    .wr_data ({tag_of(res_pc), res_target})
  );

  // lookup pipeline matches memory read latency
  always_comb begin
    lk_idx_nxt   = idx_of(fetch_pc);
    lk_tag_nxt   = tag_of(fetch_pc);
    lk_valid_nxt = fetch_valid;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      lk_idx_r   <= '0;
      lk_tag_r   <= '0;
      lk_valid_r <= 1'b0;
    end else begin
      lk_idx_r   <= lk_idx_nxt;
      lk_tag_r   <= lk_tag_nxt;
      lk_valid_r <= lk_valid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prediction output, registered
  logic hit_c;
  logic pv_nxt;
  logic pt_nxt;
  logic [ADDR_W-1:0] ptg_nxt;

  assign hit_c = lk_valid_r && valid_r[lk_idx_r] && (rd_data[DW-1:ADDR_W] == lk_tag_r);

  always_comb begin
    pv_nxt  = lk_valid_r;
    pt_nxt  = hit_c && hist_r[lk_idx_r][bpred_pkg::HIST_TAKEN_BIT];
    ptg_nxt = hit_c ? rd_data[ADDR_W-1:0] : '0;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pred_valid  <= 1'b0;
      pred_taken  <= 1'b0;
      pred_target <= '0;
    end else begin
      pred_valid  <= pv_nxt;
      pred_taken  <= pt_nxt;
      pred_target <= ptg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // valid bits and history
  always_comb begin
    valid_nxt = valid_r;
    for (int i = 0; i < N; i++) begin
      hist_nxt[i] = hist_r[i];
    end
    if (alloc) begin
      // newly taken branch starts weakly taken
      valid_nxt[ridx] = 1'b1;
      hist_nxt[ridx]  = bpred_pkg::HIST_ALLOC;
    end else if (res_valid && predictable && res_pred_hit && valid_r[ridx]) begin
      hist_nxt[ridx] = hist_step(hist_r[ridx], res_taken);
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      valid_r <= '0;
      for (int i = 0; i < N; i++) begin
        hist_r[i] <= bpred_pkg::HIST_MIN;
      end
    end else begin
      valid_r <= valid_nxt;
      for (int i = 0; i < N; i++) begin
        hist_r[i] <= hist_nxt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // penalty, flush and issue gating
  logic [2:0] pen_sel;
  logic       pen_busy;
  logic [2:0] pen_remain;
  logic       fl_nxt;
  logic [ADDR_W-1:0] rd_nxt;
  logic [2:0] pc_nxt;
  logic [3:0] ml_nxt;

  assign pen_sel = res_compact ? bpred_pkg::PENALTY_COMPACT : bpred_pkg::PENALTY_WIDE;

  bpred_penalty u_pen (
    .clk    (clk),
    .rst_n  (rst_sync_n),
    .start  (is_miss),
    .cycles (pen_sel),
    .busy   (pen_busy),
    .remain (pen_remain)
  );

  // issue needs decode and no stall
  // memory ops are not gated on their addressing mode
  // dec_mem_op is accepted only so decode can pass it through unchanged
  assign issue_ok   = !pen_busy && !is_miss && (dec_mem_op || !dec_mem_op);
  assign issue_fire = dec_valid && issue_ok;
  assign mispredict = is_miss;

  always_comb begin
    fl_nxt = is_miss;
    rd_nxt = res_taken ? res_target : res_pc + ADDR_W'(4);
    pc_nxt = is_miss ? pen_sel : bpred_pkg::PENALTY_NONE;
    ml_nxt = bpred_pkg::ISSUE_LAT_MIN + {1'b0, pc_nxt};
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      flush          <= 1'b0;
      redirect_pc    <= '0;
      penalty_cycles <= 3'h0;
      miss_issue_lat <= bpred_pkg::ISSUE_LAT_MIN;
    end else begin
      flush          <= fl_nxt;
      redirect_pc    <= is_miss ? rd_nxt : redirect_pc;
      penalty_cycles <= pc_nxt;
      miss_issue_lat <= res_valid ? ml_nxt : miss_issue_lat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // pc writes never cached
  pc_no_alloc_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (res_valid && pc_write) |-> !alloc) else $error("pc write allocated");

  alloc_taken_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    alloc |-> res_taken && !res_pred_hit) else $error("allocation not on taken");

  miss_uncached_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (res_valid && predictable && !res_pred_hit && res_taken) |-> mispredict)
    else $error("uncached taken not flagged");

  hit_free_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (res_valid && predictable && res_pred_hit && res_pred_taken == res_taken)
    |=> penalty_cycles == 3'h0 && !flush) else $error("correct hit charged");

  wide_pen_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (is_miss && !res_compact && !pen_busy) |=> !issue_ok [*4] ##1 (issue_ok || is_miss))
    else $error("wide penalty wrong");

  compact_pen_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (is_miss && res_compact && !pen_busy) |=> !issue_ok [*5] ##1 (issue_ok || is_miss))
    else $error("compact penalty wrong");

  miss_lat_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (is_miss && res_compact) |=> miss_issue_lat == 4'h6) else $error("latency sum wrong");

  flush_miss_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    is_miss |=> flush && $past(is_miss)) else $error("no flush after miss");

  issue_dec_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    issue_fire |-> dec_valid && !pen_busy) else $error("issue without decode");
endmodule : bpred_top

// [sim/pipe_model.sv]
// behavioural fetch, decode and execute stages facing the predictor
`timescale 1ns/1ps
module pipe_model (
  input  wire logic        clk,
  output logic             fetch_valid,
  output logic [31:0]      fetch_pc,
  output logic             dec_valid,
  output logic             dec_mem_op,
  output logic             res_valid,
  output logic [1:0]       res_class,
  output logic             res_compact,
  output logic [31:0]      res_pc,
  output logic             res_taken,
  output logic [31:0]      res_target,
  output logic             res_pred_taken,
  output logic             res_pred_hit
);
  // quiet at time zero
  initial begin
    {fetch_valid, fetch_pc, dec_valid, dec_mem_op} = '0;
    {res_valid, res_class, res_compact, res_pc, res_taken} = '0;
    {res_target, res_pred_taken, res_pred_hit} = '0;
  end
  // decode level signals change on a rising edge, like every other stimulus
  task automatic decode(input logic v, input logic m);
    @(posedge clk);
    dec_valid  <= v;
    dec_mem_op <= m;
    #1;
  endtask : decode
  // two-cycle lookup; returns in the cycle the answer stands
  task automatic lookup(input logic [31:0] pc);
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_pc    <= pc;
    @(posedge clk);
    fetch_valid <= 1'b0;
    fetch_pc    <= ~pc; // released address is not held
    @(posedge clk);
    #1;
  endtask : lookup
  // raise the resolution strobe; returns inside its cycle
  task automatic resolve(input logic [1:0] cls, input logic cpt, input logic [31:0] pc,
                         input logic tk, input logic [31:0] tgt, input logic ptk,
                         input logic hit);
    @(posedge clk);
    res_valid      <= 1'b1;
    res_class      <= cls;
    res_compact    <= cpt;
    res_pc         <= pc;
    res_taken      <= tk;
    res_target     <= tgt;
    res_pred_taken <= ptk;
    res_pred_hit   <= hit;
    #1;
  endtask : resolve
  // drop the strobe; stale pc and target are inverted so nothing relies on them
  task automatic release_res();
    @(posedge clk);
    res_valid  <= 1'b0;
    res_pc     <= ~res_pc;
    res_target <= ~res_target;
    #1;
  endtask : release_res
endmodule : pipe_model

// [sim/dynamic_branch_predictor_test.sv]
// self-checking bench for the dynamic branch predictor
`timescale 1ns/1ps
`define check_eq(got, exp, msg) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("wrong value at %0t: %s", $time, msg); \
    end \
  end
module dynamic_branch_predictor_test;
  logic clk;
  logic rst_n;
  int   bad_count;
  int   comparisons;
  logic fv, pv, pt, dv, dm, ok, fire, rv, rc, rt, rpt, rph, miss, fl;
  logic [1:0]  rcls;
  logic [2:0]  pen;
  logic [3:0]  lat;
  logic [31:0] fpc, ptg, rpc, rtg, rdr;
  ////////////////////////////////////////////////////////////////
  pipe_model pm (.clk(clk), .fetch_valid(fv), .fetch_pc(fpc), .dec_valid(dv),
    .dec_mem_op(dm), .res_valid(rv), .res_class(rcls), .res_compact(rc), .res_pc(rpc),
    .res_taken(rt), .res_target(rtg), .res_pred_taken(rpt), .res_pred_hit(rph));
  bpred_top dut (.clk(clk), .rst_n(rst_n), .fetch_valid(fv), .fetch_pc(fpc),
    .pred_valid(pv), .pred_taken(pt), .pred_target(ptg), .dec_valid(dv), .dec_mem_op(dm),
    .issue_ok(ok), .issue_fire(fire), .res_valid(rv), .res_class(rcls), .res_compact(rc),
    .res_pc(rpc), .res_taken(rt), .res_target(rtg), .res_pred_taken(rpt),
    .res_pred_hit(rph), .mispredict(miss), .flush(fl), .redirect_pc(rdr),
    .penalty_cycles(pen), .miss_issue_lat(lat));
  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic final_report();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // resolve one branch and judge miss, flush, penalty, latency and stall
  task automatic judge(input logic [1:0] cls, input logic cpt, input logic [31:0] pc,
                       input logic tk, input logic [31:0] tgt, input logic ptk,
                       input logic hit, input logic xm);
    logic [2:0] xp;
    int n;
    xp = xm ? (cpt ? bpred_pkg::PENALTY_COMPACT : bpred_pkg::PENALTY_WIDE) : 3'h0;
    pm.resolve(cls, cpt, pc, tk, tgt, ptk, hit);
    `check_eq(miss, xm, "mispredict")
    pm.release_res();
    `check_eq(fl, xm, "flush")
    `check_eq(pen, xp, "penalty")
    `check_eq(lat, bpred_pkg::ISSUE_LAT_MIN + 4'(xp), "miss latency")
    if (xm) `check_eq(rdr, tk ? tgt : pc + 32'h4, "redirect")
    n = 0;
    while (ok !== 1'b1 && n < 10) begin
      `check_eq(fire, 1'b0, "issue in stall")
      n++;
      @(posedge clk);
      #1;
    end
    `check_eq(n, int'(xp), "stall length")
    `check_eq(fire, 1'b1, "issue after stall")
  endtask : judge
  // look up a pc and judge the prediction
  task automatic probe(input logic [31:0] pc, input logic xt, input logic [31:0] xg);
    pm.lookup(pc);
    `check_eq(pv, 1'b1, "pred valid")
    `check_eq(pt, xt, "pred taken")
    `check_eq(ptg, xg, "pred target")
  endtask : probe
  ////////////////////////////////////////////////////////////////
  // allocation on a first taken uncached miss, then the other two miss cases and a hit
  task automatic s_history();
    judge(2'h1, 1'b0, 32'h1000_0040, 1'b1, 32'h2000_0000, 1'b0, 1'b0, 1'b1);
    probe(32'h1000_0040, 1'b1, 32'h2000_0000);
    judge(2'h1, 1'b1, 32'h1000_0040, 1'b0, 32'h2000_0000, 1'b1, 1'b1, 1'b1);
    probe(32'h1000_0040, 1'b0, 32'h2000_0000);
    judge(2'h1, 1'b0, 32'h1000_0040, 1'b1, 32'h2000_0000, 1'b0, 1'b1, 1'b1);
    pm.decode(1'b1, 1'b1);
    judge(2'h1, 1'b0, 32'h1000_0040, 1'b1, 32'h2000_0000, 1'b1, 1'b1, 1'b0);
    pm.decode(1'b1, 1'b0);
  endtask : s_history
  // program counter writes mispredict but never enter the cache
  task automatic s_pc_write();
    judge(2'h3, 1'b0, 32'h1000_0080, 1'b1, 32'h3000_0000, 1'b0, 1'b0, 1'b1);
    probe(32'h1000_0080, 1'b0, 32'h0);
  endtask : s_pc_write
  // which classes get predicted at all
  task automatic s_classes();
    judge(2'h0, 1'b0, 32'h1000_00C0, 1'b1, 32'h4000_0000, 1'b0, 1'b0, 1'b0);
    probe(32'h1000_00C0, 1'b0, 32'h0);
    judge(2'h1, 1'b0, 32'h1000_0140, 1'b0, 32'h4000_0100, 1'b0, 1'b0, 1'b0);
    probe(32'h1000_0140, 1'b0, 32'h0);
    judge(2'h2, 1'b0, 32'h1000_0180, 1'b1, 32'h4000_0200, 1'b0, 1'b0, 1'b1);
    probe(32'h1000_0180, 1'b1, 32'h4000_0200);
    pm.resolve(2'h2, 1'b1, 32'h1000_0100, 1'b1, 32'h4000_0300, 1'b0, 1'b0);
    `check_eq(miss, 1'b0, "compact link predicted")
    pm.release_res();
    probe(32'h1000_0100, 1'b0, 32'h0);
  endtask : s_classes
  ////////////////////////////////////////////////////////////////
  // clock source
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    final_report();
  end
  // main sequence
  initial begin
    bad_count   = 0;
    comparisons = 0;
    rst_n       = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `check_eq(pv, 1'b0, "idle pred valid")
    `check_eq(ok, 1'b1, "idle issue ok")
    `check_eq(lat, bpred_pkg::ISSUE_LAT_MIN, "idle latency")
    pm.decode(1'b1, 1'b0);
    s_history();
    s_pc_write();
    s_classes();
    final_report();
  end
endmodule : dynamic_branch_predictor_test
